// ### core/twc_pkg.sv
// Purpose: Shared constants for the console typewriter channel controller.
// Assumes: Octal channel codes on a 12-bit word with an odd parity line.
// Notes: Every code and field position lives here, with the status reset value.
package twc_pkg;
    // ----------------------------------------------------------------
    // Function codes
    // ----------------------------------------------------------------
    localparam logic [11:0] FN_ARM_ABEND = 12'h001;
    localparam logic [11:0] FN_DISARM_ABEND = 12'h002;
    localparam logic [11:0] FN_CLR_INT = 12'h004;
    localparam logic [11:0] FN_ARM_MANUAL = 12'h008;
    localparam logic [11:0] FN_DISARM_MANUAL = 12'h010;
    // ----------------------------------------------------------------
    // Connect code fields and status bit positions
    // ----------------------------------------------------------------
    localparam int CONN_EQ_LSB = 9;
    localparam logic [8:0] CONN_LOW_ZERO = 9'h000;
    localparam int ST_READY = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_UPPER = 2;
    localparam int ST_EOL = 5;
    localparam int ST_TPERR = 11;
    // ----------------------------------------------------------------
    // Character codes; the controller decodes only CH_CR, CH_UPPER and CH_LOWER
    // ----------------------------------------------------------------
    localparam logic [5:0] CH_SPACE = 6'h30;
    localparam logic [5:0] CH_BACKSPACE = 6'h31;
    localparam logic [5:0] CH_TAB = 6'h32;
    localparam logic [5:0] CH_CR = 6'h33;
    localparam logic [5:0] CH_UPPER = 6'h34;
    localparam logic [5:0] CH_LOWER = 6'h36;
    // Spaces past the margin stop after which end of line drops.
    localparam logic [3:0] EOL_DROP_SPACES = 4'h8;
    localparam logic [11:0] STATUS_RESET = 12'h000;
    typedef enum logic [1:0]
    {
        TWC_IDLE = 2'b00,
        TWC_PRINT = 2'b01,
        TWC_DONE = 2'b11
    } twc_state_t;
endpackage

// ### core/twc_controller.sv
// Purpose: Console typewriter controller between a host data channel and
//          a typewriter mechanism.
// Assumes: All inputs but resetn_i synchronous to mclk_i; one 50 MHz clock.
// Notes: Channel strobes are one-cycle pulses; the mechanism takes one
//        character at a time and acknowledges with a check result.
module twc_controller
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic [2:0] equip_sel_i,
    input wire logic [11:0] chan_data_i,
    input wire logic chan_parity_i,
    input wire logic chan_connect_i,
    input wire logic chan_function_i,
    input wire logic chan_write_i,
    input wire logic chan_read_req_i,
    input wire logic chan_clear_i,
    input wire logic master_clear_i,
    input wire logic mech_power_i,
    input wire logic mech_ack_i,
    input wire logic mech_check_ok_i,
    input wire logic mech_at_margin_i,
    input wire logic mech_space_i,
    input wire logic mech_key_valid_i,
    input wire logic [5:0] mech_key_code_i,
    input wire logic manual_int_pb_i,
    input wire logic record_end_pushbutton_i,
    output logic chan_reply_o,
    output logic chan_reject_o,
    output logic chan_parity_err_o,
    output logic [11:0] chan_status_o,
    output logic chan_status_valid_o,
    output logic [11:0] chan_rdata_o,
    output logic chan_rdata_parity_o,
    output logic chan_rdata_valid_o,
    output logic chan_record_end_o,
    output logic [7:0] int_lines_o,
    output logic mech_char_valid_o,
    output logic [5:0] mech_char_o,
    output logic connected_indicator_o,
    output logic transmission_parity_indicator_o,
    output logic type_in_indicator_o
);
    // ----------------------------------------------------------------
    // Reset synchroniser and qualifiers
    // ----------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic ce;
    logic par_ok;
    logic conn_req;
    logic fn_req;
    logic wr_req;
    logic clr_all;
    logic clr_chan;

    // Release is delayed two edges so no flop leaves reset on a runt edge.
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Odd total over data plus parity line means a clean transfer.
    assign par_ok = ^{chan_data_i, chan_parity_i};
    assign ce = clk_en_i;
    assign conn_req = ce && chan_connect_i;
    assign fn_req = ce && chan_function_i;
    assign wr_req = ce && chan_write_i;
    assign clr_all = master_clear_i;
    assign clr_chan = chan_clear_i || master_clear_i;

    // ----------------------------------------------------------------
    // Connection, parity indicator and channel replies
    // ----------------------------------------------------------------
    logic connected_reg;
    logic xpar_reg;
    logic match;
    logic busy;
    logic [11:0] status_word;
    twc_pkg::twc_state_t state_reg;

    assign match = (chan_data_i[11:twc_pkg::CONN_EQ_LSB] == equip_sel_i)
        && (chan_data_i[twc_pkg::CONN_EQ_LSB-1:0]
            == twc_pkg::CONN_LOW_ZERO);

    // A connect with bad parity drops any existing connection.
    always_ff @(posedge mclk_i or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            connected_reg <= 1'b0;
        else if (ce && clr_chan)
            connected_reg <= 1'b0;
        else if (conn_req)
            connected_reg <= par_ok && match;
    end

    // The indicator stays lit until a clear, as software must resync.
    always_ff @(posedge mclk_i or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            xpar_reg <= 1'b0;
        else if ((conn_req || ((fn_req || wr_req) && connected_reg))
            && !par_ok)
            xpar_reg <= 1'b1;
        else if (ce && clr_chan)
            xpar_reg <= 1'b0;
    end

    // Replies, rejects, parity error pulses and the status word.
    always_ff @(posedge mclk_i or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            chan_reply_o <= 1'b0;
            chan_reject_o <= 1'b0;
            chan_parity_err_o <= 1'b0;
            chan_status_o <= twc_pkg::STATUS_RESET;
            chan_status_valid_o <= 1'b0;
        end
        else if (ce)
        begin
            chan_reply_o <= 1'b0;
            chan_reject_o <= 1'b0;
            chan_parity_err_o <= 1'b0;
            chan_status_valid_o <= chan_status_valid_o;
            if (clr_chan)
            begin
                chan_status_o <= twc_pkg::STATUS_RESET;
                chan_status_valid_o <= 1'b0;
            end
            else if (conn_req && par_ok && match)
            begin
                chan_reply_o <= 1'b1;
                chan_status_o <= status_word;
                chan_status_valid_o <= 1'b1;
            end
            else if (conn_req && par_ok)
            begin
                chan_reject_o <= 1'b1;
                chan_status_o <= status_word;
                chan_status_valid_o <= 1'b1;
            end
            else if (conn_req)
                chan_status_valid_o <= 1'b0;
            else if (fn_req && connected_reg)
            begin
                chan_parity_err_o <= !par_ok;
                chan_reply_o <= par_ok;
            end
            else if (fn_req)
                chan_reject_o <= 1'b1;
            else if (wr_req && connected_reg && !busy)
            begin
                chan_reply_o <= 1'b1;
                chan_parity_err_o <= !par_ok;
            end
            else if (wr_req)
                chan_reject_o <= 1'b1;
            else if (chan_status_valid_o)
                chan_status_o <= status_word;
        end
    end

    // ----------------------------------------------------------------
    // Function decode: interrupt arming
    // ----------------------------------------------------------------
    logic abend_arm_reg;
    logic man_arm_reg;
    logic fn_ok;

    assign fn_ok = fn_req && connected_reg && par_ok && !clr_chan;

    always_ff @(posedge mclk_i or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            abend_arm_reg <= 1'b0;
            man_arm_reg <= 1'b0;
        end
        else if (ce && clr_chan)
        begin
            abend_arm_reg <= 1'b0;
            man_arm_reg <= 1'b0;
        end
        else if (fn_ok)
        begin
            if (chan_data_i == twc_pkg::FN_ARM_ABEND)
                abend_arm_reg <= 1'b1;
            if (chan_data_i == twc_pkg::FN_DISARM_ABEND)
                abend_arm_reg <= 1'b0;
            if (chan_data_i == twc_pkg::FN_ARM_MANUAL)
                man_arm_reg <= 1'b1;
            if (chan_data_i == twc_pkg::FN_DISARM_MANUAL)
                man_arm_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Write path to the mechanism
    // ----------------------------------------------------------------
    logic [5:0] last_char_reg;

    // One character at a time; busy spans handing off to the cycle after the ack.
    always_ff @(posedge mclk_i or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            state_reg <= twc_pkg::TWC_IDLE;
            mech_char_o <= 6'h00;
            mech_char_valid_o <= 1'b0;
            last_char_reg <= 6'h00;
        end
        else if (ce)
        begin
            if (clr_chan)
            begin
                state_reg <= twc_pkg::TWC_IDLE;
                mech_char_valid_o <= 1'b0;
            end
            else
            begin
                case (state_reg)
                    twc_pkg::TWC_IDLE:
                    begin
                        if (wr_req && connected_reg)
                        begin
                            mech_char_o <= chan_data_i[5:0];
                            last_char_reg <= chan_data_i[5:0];
                            mech_char_valid_o <= 1'b1;
                            state_reg <= twc_pkg::TWC_PRINT;
                        end
                    end
                    twc_pkg::TWC_PRINT:
                    begin
                        mech_char_valid_o <= 1'b0;
                        if (mech_ack_i)
                            state_reg <= twc_pkg::TWC_DONE;
                    end
                    twc_pkg::TWC_DONE:
                        state_reg <= twc_pkg::TWC_IDLE;
                    default:
                        state_reg <= twc_pkg::TWC_IDLE;
                endcase
            end
        end
    end

    // Function decode takes one cycle, so a function counts as busy then.
    assign busy = (state_reg != twc_pkg::TWC_IDLE) || fn_ok;

    // ----------------------------------------------------------------
    // Case shift, end of line and type parity tracking
    // ----------------------------------------------------------------
    logic upper_reg;
    logic eol_reg;
    logic tperr_reg;
    logic [3:0] past_cnt_reg;
    logic cr_done;
    logic ack_ok;

    assign ack_ok = ce && state_reg == twc_pkg::TWC_PRINT && mech_ack_i;
    assign cr_done = ack_ok && last_char_reg == twc_pkg::CH_CR;

    always_ff @(posedge mclk_i or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            upper_reg <= 1'b0;
        else if (ce && clr_all)
            upper_reg <= 1'b0;
        else if (ack_ok && last_char_reg == twc_pkg::CH_UPPER)
            upper_reg <= 1'b1;
        else if (ack_ok && last_char_reg == twc_pkg::CH_LOWER)
            upper_reg <= 1'b0;
    end

    // Reaching the stop sets end of line; no carrier return is issued.
    always_ff @(posedge mclk_i or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            eol_reg <= 1'b0;
            past_cnt_reg <= 4'h0;
        end
        else if (ce)
        begin
            if (clr_all || cr_done)
            begin
                eol_reg <= 1'b0;
                past_cnt_reg <= 4'h0;
            end
            else if (mech_at_margin_i && past_cnt_reg == 4'h0)
                eol_reg <= 1'b1;
            if (!clr_all && !cr_done && eol_reg && mech_space_i)
            begin
                past_cnt_reg <= past_cnt_reg + 4'h1;
                if (past_cnt_reg + 4'h1 >= twc_pkg::EOL_DROP_SPACES)
                    eol_reg <= 1'b0;
            end
        end
    end

    // Error wins over a carrier return landing in the same cycle.
    always_ff @(posedge mclk_i or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            tperr_reg <= 1'b0;
        else if (ack_ok && !mech_check_ok_i)
            tperr_reg <= 1'b1;
        else if (ce && (clr_all || cr_done))
            tperr_reg <= 1'b0;
    end

    always_comb
    begin
        status_word = twc_pkg::STATUS_RESET;
        status_word[twc_pkg::ST_READY] = mech_power_i;
        status_word[twc_pkg::ST_BUSY] = busy;
        status_word[twc_pkg::ST_UPPER] = upper_reg;
        status_word[twc_pkg::ST_EOL] = eol_reg;
        status_word[twc_pkg::ST_TPERR] = tperr_reg;
    end

    // ----------------------------------------------------------------
    // Interrupt, read data and panel signals
    // ----------------------------------------------------------------
    logic int_reg;
    logic int_set;
    logic eol_q_reg;
    logic tperr_q_reg;

    // Abnormal-end fires on new error or margin arrival; manual anytime.
    assign int_set = (abend_arm_reg && ((eol_reg && !eol_q_reg)
        || (tperr_reg && !tperr_q_reg)))
        || (man_arm_reg && manual_int_pb_i);

    always_ff @(posedge mclk_i or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            int_reg <= 1'b0;
            eol_q_reg <= 1'b0;
            tperr_q_reg <= 1'b0;
        end
        else if (ce)
        begin
            eol_q_reg <= eol_reg;
            tperr_q_reg <= tperr_reg;
            if (int_set)
                int_reg <= 1'b1;
            else if (clr_chan)
                int_reg <= 1'b0;
            else if (fn_ok && chan_data_i == twc_pkg::FN_CLR_INT)
                int_reg <= 1'b0;
        end
    end

    // One-hot line chosen by the switch setting.
    assign int_lines_o = {7'h00, int_reg} << equip_sel_i;

    // Keyed characters go up with odd parity when input is requested.
    always_ff @(posedge mclk_i or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            chan_rdata_o <= 12'h000;
            chan_rdata_parity_o <= 1'b0;
            chan_rdata_valid_o <= 1'b0;
            chan_record_end_o <= 1'b0;
        end
        else if (ce)
        begin
            chan_rdata_valid_o <= connected_reg && chan_read_req_i
                && mech_key_valid_i && !clr_chan;
            chan_record_end_o <= connected_reg && !clr_chan
                && record_end_pushbutton_i;
            if (mech_key_valid_i)
            begin
                chan_rdata_o <= {6'h00, mech_key_code_i};
                chan_rdata_parity_o <= ~^mech_key_code_i;
            end
        end
    end

    assign connected_indicator_o = connected_reg;
    assign transmission_parity_indicator_o = xpar_reg;
    assign type_in_indicator_o = connected_reg && chan_read_req_i;
endmodule

// ### dv/twc_mech_model.sv
// Purpose: Behavioural typewriter mechanism on the far side of the block.
// Assumes: One character is in flight at a time.
// Notes: Answer delay and a failed type check are set by the bench.
module twc_mech_model
(
    input wire logic mclk_i,
    input wire logic mech_char_valid_o,
    input wire logic bad_i,
    input wire logic [3:0] dly_i,
    output logic mech_ack_i,
    output logic mech_check_ok_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // Print each 6-bit code after a delay, then acknowledge with the check.
    // Outside the acknowledge the check line shows the inverse, so a
    // controller that samples it at the wrong time sees a wrong value.
    initial
    begin
        mech_ack_i = 1'b0;
        mech_check_ok_i = 1'b0;
        forever
        begin
            @(posedge mclk_i);
            if (mech_char_valid_o === 1'b1)
            begin
                repeat (dly_i) @(posedge mclk_i);
                mech_ack_i <= 1'b1;
                mech_check_ok_i <= !bad_i;
                @(posedge mclk_i);
                mech_ack_i <= 1'b0;
                mech_check_ok_i <= bad_i;
            end
        end
    end
endmodule

// ### dv/twc_chk.sv
// Purpose: Port-level checker for the typewriter channel controller.
// Assumes: Strobes are taken only with clk_en_i high.
// Notes: Bound to the top module; one clock domain.
module twc_chk
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic [2:0] equip_sel_i,
    input wire logic [11:0] chan_data_i,
    input wire logic chan_parity_i,
    input wire logic chan_connect_i,
    input wire logic chan_function_i,
    input wire logic chan_write_i,
    input wire logic chan_read_req_i,
    input wire logic chan_clear_i,
    input wire logic master_clear_i,
    input wire logic mech_power_i,
    input wire logic manual_int_pb_i,
    input wire logic record_end_pushbutton_i,
    input wire logic chan_reply_o,
    input wire logic chan_reject_o,
    input wire logic chan_parity_err_o,
    input wire logic [11:0] chan_status_o,
    input wire logic chan_status_valid_o,
    input wire logic chan_record_end_o,
    input wire logic [7:0] int_lines_o,
    input wire logic connected_indicator_o,
    input wire logic transmission_parity_indicator_o,
    input wire logic type_in_indicator_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    // ------------------------------------------------------------
    // Request sequences
    // ------------------------------------------------------------
    // Odd count over data and parity line means a clean transfer.
    logic odd;
    assign odd = ^{chan_data_i, chan_parity_i};
    sequence s_conn_ok;
        chan_connect_i && clk_en_i && odd
            && chan_data_i == {equip_sel_i, 9'h000};
    endsequence
    sequence s_fn_bad;
        chan_function_i && clk_en_i && !odd && connected_indicator_o;
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    conn_match_a:
        assert property (s_conn_ok |=> chan_reply_o && connected_indicator_o)
        else $error("matching connect not answered");
    conn_foreign_a:
        assert property (chan_connect_i && clk_en_i
            && chan_data_i[11:9] != equip_sel_i |=> !chan_reply_o)
        else $error("foreign connect answered");
    conn_parity_a:
        assert property (chan_connect_i && clk_en_i && !odd
            |=> transmission_parity_indicator_o && !chan_reply_o)
        else $error("bad connect parity not flagged");
    fn_parity_a:
        assert property (s_fn_bad |=> chan_parity_err_o && !chan_reply_o
            && !chan_reject_o)
        else $error("bad function parity not flagged");
    int_line_a:
        assert property (int_lines_o == 8'h00
            || int_lines_o == (8'h01 << equip_sel_i))
        else $error("interrupt on wrong line");
    type_in_a:
        assert property (type_in_indicator_o
            == (connected_indicator_o && chan_read_req_i))
        else $error("type in indicator wrong");
    int_hold_a:
        assert property (|int_lines_o && !chan_clear_i && !master_clear_i
            && !(chan_function_i && chan_data_i == twc_pkg::FN_CLR_INT)
            |=> |int_lines_o)
        else $error("interrupt dropped on its own");
    int_clear_a:
        assert property (chan_function_i && clk_en_i && odd
            && connected_indicator_o && !manual_int_pb_i
            && chan_data_i == twc_pkg::FN_CLR_INT |=> int_lines_o == 8'h00)
        else $error("clear interrupt ignored");
    rec_end_a:
        assert property (chan_record_end_o |-> $past(record_end_pushbutton_i)
            && $past(connected_indicator_o))
        else $error("record end without cause");
    ready_bit_a:
        assert property (chan_status_valid_o && $stable(mech_power_i)
            |-> chan_status_o[twc_pkg::ST_READY] == mech_power_i)
        else $error("ready bit wrong");
    reject_a:
        assert property (chan_write_i && clk_en_i && !connected_indicator_o
            |=> chan_reject_o && !chan_reply_o)
        else $error("write while disconnected not rejected");
    mclear_a:
        assert property ($fell(master_clear_i) |-> !chan_status_valid_o
            && int_lines_o == 8'h00)
        else $error("master clear left state");
endmodule

bind twc_controller twc_chk twc_chk_inst (.*);

// ### dv/tb_twc_controller.sv
// Purpose: Self-checking bench for the typewriter channel controller.
// Assumes: Mechanism model answers every printed character.
// Notes: A small integer model predicts status and interrupt lines.
module tb_twc_controller;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 0, resetn_i = 0, clk_en_i = 1, chan_parity_i = 0;
    logic [2:0] equip_sel_i = 0;
    logic [11:0] chan_data_i = 0;
    logic chan_connect_i = 0, chan_function_i = 0, chan_write_i = 0;
    logic chan_read_req_i = 0, chan_clear_i = 0, master_clear_i = 0;
    logic mech_power_i = 1, mech_at_margin_i = 0, mech_space_i = 0;
    logic mech_key_valid_i = 0, manual_int_pb_i = 0;
    logic record_end_pushbutton_i = 0, mech_bad = 0;
    logic [5:0] mech_key_code_i = 0, mech_char_o;
    logic [3:0] mech_dly = 4'h2;
    logic mech_ack_i, mech_check_ok_i, chan_reply_o, chan_reject_o;
    logic chan_parity_err_o, chan_status_valid_o, chan_rdata_parity_o;
    logic chan_rdata_valid_o, chan_record_end_o, mech_char_valid_o;
    logic connected_indicator_o, transmission_parity_indicator_o;
    logic type_in_indicator_o;
    logic [11:0] chan_status_o, chan_rdata_o;
    logic [7:0] int_lines_o;
    logic [31:0] x;
    int n_mismatch = 0, num_checks = 0, i;
    int conn, arm_a, arm_m, intr, upr, eol, tperr, xp;

    twc_controller twc_controller_inst (.*);
    twc_mech_model twc_mech_model_inst (.mclk_i, .mech_char_valid_o,
        .bad_i(mech_bad), .dly_i(mech_dly), .mech_ack_i, .mech_check_ok_i);

    // Free-running 50 MHz clock.
    always #10 mclk_i = ~mclk_i;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic test_done;
        if (n_mismatch == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [11:0] s,
        input logic [11:0] e);
        num_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask

    // Compare interrupt lines, status word and valid, connect and parity indicators against the model.
    task automatic cmp;
        chk("int", {4'h0, int_lines_o}, intr ? 8'h01 << equip_sel_i : 0);
        chk("valid", chan_status_valid_o, conn[0]);
        chk("conn", connected_indicator_o, conn[0]);
        chk("xmsn", transmission_parity_indicator_o, xp[0]);
        chk("status", chan_status_valid_o ? chan_status_o : 12'h0,
            conn ? {tperr[0], 5'h0, eol[0], 2'h0, upr[0], 1'b0,
            mech_power_i} : 12'h0);
    endtask

    // One channel strobe: 0 connect, 1 function, 2 write.
    task automatic go(input int k, input logic [11:0] d, input logic bad);
        @(posedge mclk_i);
        chan_data_i <= d;
        chan_parity_i <= (~^d) ^ bad;
        chan_connect_i <= (k == 0);
        chan_function_i <= (k == 1);
        chan_write_i <= (k == 2);
        @(posedge mclk_i);
        {chan_connect_i, chan_function_i, chan_write_i} <= 3'b000;
        #1;
    endtask

    task automatic fn(input logic [11:0] c);
        go(1, c, 0);
        chk("reply", chan_reply_o, 1);
        arm_a = c == 12'h001 ? 1 : c == 12'h002 ? 0 : arm_a;
        arm_m = c == 12'h008 ? 1 : c == 12'h010 ? 0 : arm_m;
        intr = c == 12'h004 ? 0 : intr;
        repeat (2) @(posedge mclk_i);
        #1;
        cmp;
    endtask

    task automatic wr(input logic [5:0] c, input logic bad);
        mech_bad <= bad;
        mech_dly <= 4'h1 + 4'(rnd() & 32'h7);
        go(2, {6'h00, c}, 0);
        chk("reply", chan_reply_o, 1);
        chk("char", mech_char_o, c);
        @(posedge mclk_i);
        #1;
        chk("busy", chan_status_o[1], 1);
        for (i = 0; i < 40; i++)
        begin
            if (mech_ack_i === 1'b1)
                break;
            @(posedge mclk_i);
            #1;
        end
        if (i == 40)
        begin
            n_mismatch++;
            test_done();
        end
        repeat (3) @(posedge mclk_i);
        #1;
        intr = (bad && !tperr && arm_a) ? 1 : intr;
        tperr = bad ? 1 : c == 6'h33 ? 0 : tperr;
        eol = c == 6'h33 ? 0 : eol;
        upr = c == 6'h34 ? 1 : c == 6'h36 ? 0 : upr;
        cmp;
    endtask

    // Pulse input w for n cycles from a rising edge, then settle:
    // 0 clear channel, 1 manual button, 2 margin, 3 space, 4 master clear.
    task automatic press(input int w, input int n = 2);
        for (int k = 1; k >= 0; k--)
        begin
            repeat (k ? 1 : n) @(posedge mclk_i);
            case (w)
                0: chan_clear_i <= k[0];
                1: manual_int_pb_i <= k[0];
                2: mech_at_margin_i <= k[0];
                3: mech_space_i <= k[0];
                default: master_clear_i <= k[0];
            endcase
        end
        repeat (3) @(posedge mclk_i);
        #1;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        x = 32'h3d06a145;
        {conn, arm_a, arm_m, intr, upr, eol, tperr, xp} = '0;
        equip_sel_i <= 3'(rnd());
        repeat (8) @(posedge mclk_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        #1;
        cmp;
        go(0, {equip_sel_i + 3'h1, 9'h000}, 0);
        chk("reply", chan_reply_o, 0);
        go(0, {equip_sel_i, 9'h000}, 1);
        xp = 1;
        chk("reply", chan_reply_o, 0);
        press(0);
        xp = 0;
        cmp;
        go(0, {equip_sel_i, 9'h000}, 0);
        chk("reply", chan_reply_o, 1);
        conn = 1;
        for (int n = 0; n < 4; n++)
            wr(6'(rnd()), 0);
        fn(twc_pkg::FN_ARM_MANUAL);
        press(1);
        intr = 1;
        cmp;
        fn(twc_pkg::FN_DISARM_MANUAL);
        fn(twc_pkg::FN_CLR_INT);
        press(1);
        cmp;
        fn(twc_pkg::FN_ARM_ABEND);
        press(2);
        eol = 1;
        intr = 1;
        cmp;
        fn(twc_pkg::FN_DISARM_ABEND);
        fn(twc_pkg::FN_CLR_INT);
        for (int k = 1; k <= 8; k++)
        begin
            press(3, 1);
            eol = k == 8 ? 0 : eol;
            cmp;
        end
        fn(twc_pkg::FN_ARM_ABEND);
        wr(twc_pkg::CH_SPACE, 1);
        wr(twc_pkg::CH_CR, 0);
        wr(twc_pkg::CH_UPPER, 0);
        wr(twc_pkg::CH_LOWER, 0);
        fn(twc_pkg::FN_CLR_INT);
        go(1, twc_pkg::FN_ARM_MANUAL, 1);
        chk("perr", chan_parity_err_o, 1);
        xp = 1;
        @(posedge mclk_i);
        chan_read_req_i <= 1'b1;
        record_end_pushbutton_i <= 1'b1;
        mech_key_valid_i <= 1'b1;
        mech_key_code_i <= 6'(rnd());
        @(posedge mclk_i);
        mech_key_valid_i <= 1'b0;
        #1;
        chk("rvalid", chan_rdata_valid_o, 1);
        chk("rdata", chan_rdata_o, {6'h00, mech_key_code_i});
        chk("rpar", chan_rdata_parity_o, ~^mech_key_code_i);
        @(posedge mclk_i);
        #1;
        chk("rvalid", chan_rdata_valid_o, 0);
        chk("recend", chan_record_end_o, 1);
        chk("typein", type_in_indicator_o, 1);
        chan_read_req_i <= 1'b0;
        record_end_pushbutton_i <= 1'b0;
        mech_power_i <= 1'b0;
        press(1);
        cmp;
        press(4);
        {conn, arm_a, arm_m, intr, upr, eol, tperr, xp} = '0;
        cmp;
        clk_en_i <= 1'b0;
        go(0, {equip_sel_i, 9'h000}, 0);
        chk("frozen", connected_indicator_o, 0);
        clk_en_i <= 1'b1;
        go(2, 12'h030, 0);
        chk("reject", chan_reject_o, 1);
        test_done();
    end
endmodule
